/* File: rtl/otc_pkg.sv */
package otc_pkg;

  // Two-wire device addresses in 7-bit form (0xA0 and 0xA2 on the wire).
  localparam logic [6:0] ID_DEV_ADDR   = 7'h50;
  localparam logic [6:0] DIAG_DEV_ADDR = 7'h51;

  // Diagnostic memory offsets.
  localparam logic [7:0] STATUS_OFS    = 8'h6e;
  localparam logic [7:0] MON_TEMP_OFS  = 8'h60;
  localparam logic [7:0] MON_VCC_OFS   = 8'h62;
  localparam logic [7:0] MON_BIAS_OFS  = 8'h64;
  localparam logic [7:0] MON_TXP_OFS   = 8'h66;
  localparam logic [7:0] MON_RXP_OFS   = 8'h68;

  // Field positions in the status byte.
  localparam int HW_DIS_BIT = 7;
  localparam int SW_DIS_BIT = 6;
  localparam int FAULT_BIT  = 2;
  localparam int LOS_BIT    = 1;

  // Reset values.
  localparam logic SW_DIS_RST  = 1'b0;
  localparam logic PIN_DIS_RST = 1'b1;

  // Laser power window for the fault check.
  localparam logic [15:0] TX_PWR_MIN = 16'h0400;
  localparam logic [15:0] TX_PWR_MAX = 16'hf000;

  // Power check is blanked while the laser settles after enable.
  localparam int          CLK_MHZ          = 250;
  localparam int          FAULT_BLANK_NS   = 1000;
  localparam int          FAULT_BLANK_CYC  = (FAULT_BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam logic [8:0]  FAULT_BLANK_LOAD = 9'(FAULT_BLANK_CYC);

  typedef enum logic [3:0] {
    TWS_IDLE,
    TWS_ADDR,
    TWS_WORD,
    TWS_WRITE,
    TWS_ACK,
    TWS_READ,
    TWS_RACK
  } otc_tws_state_type;

  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] vcc;
    logic [15:0] bias;
    logic [15:0] tx_pwr;
    logic [15:0] rx_pwr;
  } otc_monitor_type;

  typedef struct packed {
    logic              scl_m;
    logic              scl_s;
    logic              scl_p;
    logic              sda_m;
    logic              sda_s;
    logic              sda_p;
    logic              dis_m;
    logic              dis_s;
    logic              dis_p;
    logic              los_m;
    logic              los_s;
    otc_tws_state_type st;
    otc_tws_state_type nxt;
    logic [2:0]        cnt;
    logic [7:0]        shreg;
    logic [7:0]        ptr;
    logic              diag_sel;
    logic              ack;
    logic              phase;
    logic              sda_drv;
    logic              sw_dis;
    logic              fault;
    logic [8:0]        blank;
    logic              laser_en;
    logic              rx_los;
  } otc_state_type;

  localparam otc_state_type OTC_STATE_RST = '{
    scl_m:  1'b1,
    scl_s:  1'b1,
    scl_p:  1'b1,
    sda_m:  1'b1,
    sda_s:  1'b1,
    sda_p:  1'b1,
    dis_m:  PIN_DIS_RST,
    dis_s:  PIN_DIS_RST,
    dis_p:  PIN_DIS_RST,
    st:     TWS_IDLE,
    nxt:    TWS_IDLE,
    sw_dis: SW_DIS_RST,
    blank:  FAULT_BLANK_LOAD,
    default: '0
  };

endpackage

/* File: rtl/otc_tx_control.sv */
`timescale 1ns/1ps

// Operation
// - Laser output is off while the shut-off pin is high, on when low.
// - Shut-off pin idles high, so the laser stays off until driven low.
// - A rising edge on the shut-off pin resets the transmit fault state.
// - Software shut-off bit sits at bit 6 of diagnostic byte 110.
// - Bit 7 of diagnostic byte 110 reports the shut-off pin state.
// - Laser is disabled when the software bit or the pin is set.
// - Reset clears the software shut-off bit, re-enabling the laser.
// - A laser fault raises the fault output and turns the laser off.
// - Fault output is low in normal operation and high on a fault.
// - Laser power below the minimum or above the maximum is a fault.
// - Fault latches; only a pin toggle or reset clears it.
// - Latched fault reads at bit 2 of diagnostic byte 110.
// - Device 0xA0 answers reads from a 256-byte identification memory.
// - Device 0xA2 answers accesses to a 256-byte diagnostic memory.
// - Diagnostic memory shows bias, transmit power, supply, temperature, receive power.
// - Shut-off and receive-loss status are mirrored into diagnostic memory.
// - Receive-loss bit is high without signal and reads at bit 1 of byte 110.
module otc_tx_control
  import otc_pkg::*;
#(
  parameter logic [7:0] ID_ROM [256] = '{default: 8'h00}
)
(
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            tx_disable_i,
  input  wire logic            receive_signal_lost_i,
  input  wire otc_monitor_type monitor_i,
  input  wire logic            scl_i,
  input  wire logic            sda_i,
  output logic                 sda_o,
  output logic                 sda_oe_o,
  output logic                 tx_fault_o,
  output logic                 tx_fault_oe_o,
  output logic                 laser_en_o,
  output logic                 receive_signal_lost_o
);

  otc_state_type q;
  otc_state_type d;

  logic          scl_rise;
  logic          scl_fall;
  logic          start_seen;
  logic          stop_seen;
  logic          any_dis;
  logic          fault_set;
  logic          fault_clr;
  logic [7:0]    rx_byte;

  // Picks the high or low byte of a 16-bit monitor value.
  function automatic logic [7:0] mon_byte(input logic [15:0] val, input logic lsb);
    mon_byte = lsb ? val[7:0] : val[15:8];
  endfunction

  // Tells whether an offset falls on either byte of a 16-bit monitor word.
  function automatic logic word_hit(input logic [7:0] ofs, input logic [7:0] base);
    word_hit = (ofs[7:1] == base[7:1]);
  endfunction

  // Tells whether a synchronised level has just gone from low to high.
  function automatic logic went_high(input logic now_lvl, input logic prev_lvl);
    went_high = now_lvl & ~prev_lvl;
  endfunction

  // Tells whether a laser power reading lies outside the allowed window.
  function automatic logic pwr_bad(input logic [15:0] pwr);
    pwr_bad = (pwr < TX_PWR_MIN) || (pwr > TX_PWR_MAX);
  endfunction

  // Open-drain drive: the line is pulled low to send a zero.
  function automatic logic pull_for(input logic b);
    pull_for = ~b;
  endfunction

  // Advances the bit counter within a byte.
  function automatic logic [2:0] next_bit(input logic [2:0] cnt);
    next_bit = cnt + 3'h1;
  endfunction

  // Advances the shared memory pointer, wrapping from the last byte to the first.
  function automatic logic [7:0] next_ofs(input logic [7:0] ofs);
    next_ofs = ofs + 8'h01;
  endfunction

  // Builds the status byte from the mirrored pins and the control bits.
  function automatic logic [7:0] status_byte();
    logic [7:0] s;
    s             = 8'h00;
    s[HW_DIS_BIT] = q.dis_s;
    s[SW_DIS_BIT] = q.sw_dis;
    s[FAULT_BIT]  = q.fault;
    s[LOS_BIT]    = q.rx_los;
    status_byte   = s;
  endfunction

  // Tells whether a received address byte names this device.
  function automatic logic addr_hit(input logic [7:0] b, input logic [6:0] dev);
    addr_hit = (b[7:1] == dev);
  endfunction

  // Read data for the selected memory at the given offset.
  function automatic logic [7:0] rd_byte(input logic diag, input logic [7:0] ofs);
    logic [7:0] r;
    r = 8'h00;
    if (!diag)
    begin
      r = ID_ROM[ofs];
    end
    else if (word_hit(ofs, MON_TEMP_OFS))
    begin
      r = mon_byte(monitor_i.temp, ofs[0]);
    end
    else if (word_hit(ofs, MON_VCC_OFS))
    begin
      r = mon_byte(monitor_i.vcc, ofs[0]);
    end
    else if (word_hit(ofs, MON_BIAS_OFS))
    begin
      r = mon_byte(monitor_i.bias, ofs[0]);
    end
    else if (word_hit(ofs, MON_TXP_OFS))
    begin
      r = mon_byte(monitor_i.tx_pwr, ofs[0]);
    end
    else if (word_hit(ofs, MON_RXP_OFS))
    begin
      r = mon_byte(monitor_i.rx_pwr, ofs[0]);
    end
    else if (ofs == STATUS_OFS)
    begin
      r = status_byte();
    end
    rd_byte = r;
  endfunction

  assign scl_rise   = went_high(q.scl_s, q.scl_p);
  assign scl_fall   = ~q.scl_s & q.scl_p;
  assign start_seen = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
  assign stop_seen  = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
  assign rx_byte    = {q.shreg[6:0], q.sda_s};

  assign any_dis   = q.dis_s | q.sw_dis | q.fault;
  assign fault_set = ~any_dis && (q.blank == 9'h000) && pwr_bad(monitor_i.tx_pwr);
  assign fault_clr = went_high(q.dis_s, q.dis_p);

  always_comb
  begin
    d = q;

    // Pins pass two flip-flops before any logic looks at them.
    d.scl_m  = scl_i;
    d.scl_s  = q.scl_m;
    d.scl_p  = q.scl_s;
    d.sda_m  = sda_i;
    d.sda_s  = q.sda_m;
    d.sda_p  = q.sda_s;
    d.dis_m  = tx_disable_i;
    d.dis_s  = q.dis_m;
    d.dis_p  = q.dis_s;
    d.los_m  = receive_signal_lost_i;
    d.los_s  = q.los_m;
    d.rx_los = q.los_s;

    // Power check waits for the laser to settle after each enable.
    if (any_dis)
    begin
      d.blank = FAULT_BLANK_LOAD;
    end
    else if (q.blank != 9'h000)
    begin
      d.blank = q.blank - 9'h001;
    end

    // A new fault wins over a clear in the same cycle.
    if (fault_set)
    begin
      d.fault = 1'b1;
    end
    else if (fault_clr)
    begin
      d.fault = 1'b0;
    end

    // The laser follows the new fault value, so it goes dark with the fault output.
    d.laser_en = ~(q.dis_s | q.sw_dis | d.fault);

    // Two-wire slave.
    if (start_seen)
    begin
      d.st      = TWS_ADDR;
      d.cnt     = 3'h0;
      d.sda_drv = 1'b0;
    end
    else if (stop_seen)
    begin
      d.st      = TWS_IDLE;
      d.sda_drv = 1'b0;
    end
    else
    begin
      case (q.st)
        TWS_ADDR, TWS_WORD, TWS_WRITE:
        begin
          if (scl_rise)
          begin
            d.shreg = rx_byte;
            d.cnt   = next_bit(q.cnt);
            if (q.cnt == 3'h7)
            begin
              d.st    = TWS_ACK;
              d.phase = 1'b0;
              d.ack   = 1'b1;
              if (q.st == TWS_ADDR)
              begin
                if (addr_hit(rx_byte, DIAG_DEV_ADDR))
                begin
                  d.diag_sel = 1'b1;
                  d.nxt      = rx_byte[0] ? TWS_READ : TWS_WORD;
                end
                else if (addr_hit(rx_byte, ID_DEV_ADDR))
                begin
                  d.diag_sel = 1'b0;
                  d.nxt      = rx_byte[0] ? TWS_READ : TWS_WORD;
                end
                else
                begin
                  d.ack = 1'b0;
                  d.nxt = TWS_IDLE;
                end
              end
              else if (q.st == TWS_WORD)
              begin
                d.ptr = rx_byte;
                d.nxt = TWS_WRITE;
              end
              else
              begin
                if (q.diag_sel && (q.ptr == STATUS_OFS))
                begin
                  d.sw_dis = rx_byte[SW_DIS_BIT];
                end
                d.ptr = next_ofs(q.ptr);
                d.nxt = TWS_WRITE;
              end
            end
          end
        end
        TWS_ACK:
        begin
          if (scl_fall)
          begin
            if (!q.phase)
            begin
              d.sda_drv = q.ack;
              d.phase   = 1'b1;
            end
            else
            begin
              d.st  = q.nxt;
              d.cnt = 3'h0;
              if (q.nxt == TWS_READ)
              begin
                d.shreg   = rd_byte(q.diag_sel, q.ptr);
                d.sda_drv = pull_for(d.shreg[7]);
              end
              else
              begin
                d.sda_drv = 1'b0;
              end
            end
          end
        end
        TWS_READ:
        begin
          if (scl_fall)
          begin
            if (q.cnt == 3'h7)
            begin
              d.sda_drv = 1'b0;
              d.st      = TWS_RACK;
              d.phase   = 1'b0;
              d.ptr     = next_ofs(q.ptr);
            end
            else
            begin
              d.cnt     = next_bit(q.cnt);
              d.shreg   = {q.shreg[6:0], 1'b0};
              d.sda_drv = pull_for(q.shreg[6]);
            end
          end
        end
        TWS_RACK:
        begin
          if (scl_rise)
          begin
            d.phase = 1'b1;
            d.ack   = ~q.sda_s;
            if (q.sda_s)
            begin
              d.st = TWS_IDLE;
            end
          end
          else if (scl_fall && q.phase)
          begin
            d.st      = TWS_READ;
            d.cnt     = 3'h0;
            d.shreg   = rd_byte(q.diag_sel, q.ptr);
            d.sda_drv = pull_for(d.shreg[7]);
          end
        end
        default:
        begin
          d.sda_drv = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      q <= OTC_STATE_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign sda_o                 = 1'b0;
  assign sda_oe_o              = q.sda_drv;
  // The fault pin is open collector and is held low while no fault is latched.
  assign tx_fault_o            = 1'b0;
  assign tx_fault_oe_o         = ~q.fault;
  assign laser_en_o            = q.laser_en;
  assign receive_signal_lost_o = q.rx_los;

endmodule

/* File: verification/otc_tx_control_checker.sv */
`timescale 1ns/1ps
module otc_tx_control_checker
  import otc_pkg::*;
(
  input wire logic            clk_i,
  input wire logic            rst_n_i,
  input wire logic            tx_disable_i,
  input wire logic            receive_signal_lost_i,
  input wire otc_monitor_type monitor_i,
  input wire logic            scl_i,
  input wire logic            sda_i,
  input wire logic            sda_o,
  input wire logic            sda_oe_o,
  input wire logic            tx_fault_o,
  input wire logic            tx_fault_oe_o,
  input wire logic            laser_en_o,
  input wire logic            receive_signal_lost_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_DIS_OFF: assert property (tx_disable_i [*5] |-> !laser_en_o)
    else $error("laser lit with pin high");
  AST_EN_CAUSE: assert property ($rose(laser_en_o) |-> !$past(tx_disable_i, 3) && tx_fault_oe_o)
    else $error("laser enabled without cause");
  AST_FLT_LASER: assert property (!tx_fault_oe_o |-> !laser_en_o)
    else $error("laser lit during fault");
  AST_FLT_CAUSE: assert property ($fell(tx_fault_oe_o) |-> $past(laser_en_o) || $past(laser_en_o, 2))
    else $error("fault with laser dark");
  AST_FLT_CLEAR: assert property ($rose(tx_fault_oe_o) |-> $past(tx_disable_i, 3))
    else $error("fault cleared without pin toggle");
  AST_LOST_HI: assert property (receive_signal_lost_i [*5] |-> receive_signal_lost_o)
    else $error("signal loss not shown");
  AST_LOST_LO: assert property (!receive_signal_lost_i [*5] |-> !receive_signal_lost_o)
    else $error("signal loss shown wrongly");
  AST_OD_CONST: assert property (sda_o == 1'b0 && tx_fault_o == 1'b0)
    else $error("open drain output driven high");
  AST_SDA_SCL: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i))
    else $error("data line moved with clock high");
  cover property ($fell(tx_fault_oe_o));
  cover property ($rose(tx_fault_oe_o));
  cover property ($rose(sda_oe_o));
endmodule

/* File: verification/otc_host_model.sv */
`timescale 1ns/1ps
module otc_host_model
  import otc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic sda_oe_i,
  output logic      scl_o,
  output logic      sda_o,
  output logic      dis_o
);
  logic low_q = 1'b0;
  logic drv_q = 1'b0;
  logic val_q = 1'b0;
  initial scl_o = 1'b1;
  // Data line idles high through its pull-up.
  assign sda_o = !(low_q || sda_oe_i);
  assign dis_o = drv_q ? val_q : 1'b1;
  task automatic pin(input logic drv, input logic val);
    @(posedge clk_i);
    drv_q <= drv;
    val_q <= val;
  endtask
  task automatic step(input logic scl, input logic low);
    repeat (8) @(posedge clk_i);
    scl_o <= scl;
    low_q <= low;
  endtask
  task automatic bit_io(input logic b, output logic r);
    step(1'b0, low_q);
    step(1'b0, !b);
    step(1'b1, !b);
    repeat (8) @(posedge clk_i);
    r = sda_o;
  endtask
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic nak);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(1'b1, nak);
  endtask
  task automatic frame(input logic stop);
    step(1'b0, stop);
    step(1'b1, stop);
    step(1'b1, !stop);
  endtask
  task automatic xact(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] wd,
                      input logic rd, output logic [7:0] q, output logic nak);
    logic [7:0] x;
    logic       a;
    frame(1'b0);
    byte_io({dev, 1'b0}, x, nak);
    byte_io(ofs, x, a);
    if (rd)
      frame(1'b0);
    if (rd)
      byte_io({dev, 1'b1}, x, a);
    byte_io(rd ? 8'hff : wd, q, a);
    frame(1'b1);
  endtask
endmodule

/* File: verification/otc_tx_control_tb.sv */
`timescale 1ns/1ps
module otc_tx_control_tb
  import otc_pkg::*;
();
  typedef struct packed {logic [6:0] dev; logic [7:0] ofs; logic [15:0] exp;} otc_row_type;
  otc_monitor_type mon = '{16'h1234, 16'h5678, 16'h9abc, 16'h2000, 16'h0fed};
  otc_row_type     rows [7];
  logic            clk_i = 1'b0;
  logic            rst_n_i = 1'b0;
  logic            lost = 1'b0;
  logic            scl, sda, dis, sda_oe, flt_oe, laser, lost_o, nak;
  logic [7:0]      q;
  int              num_errors = 0;
  int              cmp_count = 0;
  initial forever #2 clk_i = !clk_i;
  otc_tx_control #(.ID_ROM('{default: 8'h3c})) otc_tx_control_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .tx_disable_i(dis), .receive_signal_lost_i(lost),
    .monitor_i(mon), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .tx_fault_o(),
    .tx_fault_oe_o(flt_oe), .laser_en_o(laser), .receive_signal_lost_o(lost_o));
  otc_host_model otc_host_model_inst (
    .clk_i(clk_i), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda), .dis_o(dis));
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(input logic [6:0] dev, input logic [7:0] ofs);
    otc_host_model_inst.xact(dev, ofs, 8'h00, 1'b1, q, nak);
  endtask
  task automatic status(input logic [7:0] exp);
    rd(DIAG_DEV_ADDR, STATUS_OFS);
    chk("status", q, exp);
  endtask
  task automatic do_reset();
    rst_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask
  initial
  begin
    repeat (60000) @(posedge clk_i);
    num_errors++;
    report_and_stop();
  end
  initial
  begin
    rows = '{'{ID_DEV_ADDR, 8'h10, 16'h3c3c}, '{DIAG_DEV_ADDR, MON_TEMP_OFS, mon.temp},
             '{DIAG_DEV_ADDR, MON_VCC_OFS, mon.vcc}, '{DIAG_DEV_ADDR, MON_BIAS_OFS, mon.bias},
             '{DIAG_DEV_ADDR, MON_TXP_OFS, mon.tx_pwr}, '{DIAG_DEV_ADDR, MON_RXP_OFS, mon.rx_pwr},
             '{DIAG_DEV_ADDR, 8'h70, 16'h0000}};
    do_reset();
    chk("laser", laser, 1'b0);
    status(8'h80);
    otc_host_model_inst.pin(1'b1, 1'b0);
    repeat (8) @(posedge clk_i);
    chk("laser", laser, 1'b1);
    chk("fault", flt_oe, 1'b1);
    for (int i = 0; i < 7; i++)
    begin
      rd(rows[i].dev, rows[i].ofs);
      chk("high byte", q, rows[i].exp[15:8]);
      rd(rows[i].dev, rows[i].ofs + 8'h01);
      chk("low byte", q, rows[i].exp[7:0]);
    end
    rd(DIAG_DEV_ADDR, MON_BIAS_OFS);
    otc_host_model_inst.frame(1'b0);
    otc_host_model_inst.byte_io({DIAG_DEV_ADDR, 1'b1}, q, nak);
    chk("ack", nak, 1'b0);
    for (int i = 7; i >= 0; i--)
      otc_host_model_inst.bit_io(1'b1, q[i]);
    otc_host_model_inst.bit_io(1'b0, nak);
    chk("next byte", q, mon.bias[7:0]);
    otc_host_model_inst.byte_io(8'hff, q, nak);
    otc_host_model_inst.frame(1'b1);
    chk("next word", q, mon.tx_pwr[15:8]);
    $display("row reads done");
    otc_host_model_inst.xact(DIAG_DEV_ADDR, STATUS_OFS, 8'h40, 1'b0, q, nak);
    chk("ack", nak, 1'b0);
    repeat (8) @(posedge clk_i);
    chk("laser", laser, 1'b0);
    status(8'h40);
    lost <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("lost pin", lost_o, 1'b1);
    status(8'h42);
    lost <= 1'b0;
    do_reset();
    chk("laser", laser, 1'b1);
    otc_host_model_inst.xact(7'h52, 8'h00, 8'h00, 1'b0, q, nak);
    chk("nack", nak, 1'b1);
    $display("shut-off and reset done");
    mon.tx_pwr <= 16'h0100;
    repeat (300) @(posedge clk_i);
    chk("fault", flt_oe, 1'b0);
    chk("laser", laser, 1'b0);
    mon.tx_pwr <= 16'h2000;
    status(8'h04);
    otc_host_model_inst.pin(1'b1, 1'b1);
    repeat (20) @(posedge clk_i);
    otc_host_model_inst.pin(1'b1, 1'b0);
    repeat (8) @(posedge clk_i);
    chk("fault", flt_oe, 1'b1);
    chk("laser", laser, 1'b1);
    mon.tx_pwr <= 16'hf100;
    repeat (300) @(posedge clk_i);
    chk("fault", flt_oe, 1'b0);
    mon.tx_pwr <= 16'h2000;
    do_reset();
    chk("fault", flt_oe, 1'b1);
    $display("fault tests done");
    report_and_stop();
  end
endmodule
bind otc_tx_control otc_tx_control_checker otc_tx_control_checker_inst (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .tx_disable_i(tx_disable_i),
  .receive_signal_lost_i(receive_signal_lost_i), .monitor_i(monitor_i), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .tx_fault_o(tx_fault_o),
  .tx_fault_oe_o(tx_fault_oe_o), .laser_en_o(laser_en_o),
  .receive_signal_lost_o(receive_signal_lost_o));
